// ==== rtl/smbus_charger_input_limit_regs.sv ====
// SMBus slave register block of a charger controller: input limit, charge setpoints, safety timers.
// Assumes a 50 MHz clk, synchronous reset, open-drain SDA resolved outside.
//
// Overview of operation
// - Limit kept as 16-bit word; DAC code is bits 12..7.
// - Code bit weights run 256 mA up to 8192 mA, summed.
// - Requests above the maximum clamp to the maximum limit code.
// - Requests below 256 mA give a zero limit code.
// - After reset the limit is 256 mA.
// - Limit reached at code 0x3F by word write and word read.
// - Charge current reached at code 0x14 by word write.
// - No charge register write for 175 s stops charging.
// - Clock low longer than 25 ms stops charging.
// - A charge register write re-enables charging after a timeout.
// - Registers are 16 bits moved as two bytes.
// - Low byte travels first, high byte second, both directions.
// - Device acknowledges address, code and both data bytes of a write.
// - New setting takes effect only at the Stop.
// - One register per write; no auto-advance.
// - Read: set code, Stop, restart reading; host acks low, nacks high.
// - One register per read.
// - Charge registers reset to zero; charging off until both valid.
`timescale 1ns/10ps
`default_nettype none
module smbus_charger_input_limit_regs #(
    parameter logic [6:0]  SLAVE_ADDR = charger_pkg::SLAVE_ADDR_DEFAULT,
    parameter logic [15:0] MAKER_ID   = 16'h00A5, // Arbitrary value
    parameter logic [15:0] PART_ID    = 16'h005A, // Arbitrary value
    parameter logic [33:0] WD_CYCLES  = 34'(charger_pkg::WRITE_TIMEOUT_CYC),
    parameter logic [20:0] LOW_CYCLES = 21'(charger_pkg::SCL_LOW_CYC)
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    output charger_pkg::dac_out_t  dac
);
    import charger_pkg::*;

    typedef struct packed {
        bus_state_t  st;
        logic [3:0]  bitcnt;
        logic        in_ack;
        logic        nack;
        logic [7:0]  shreg;
        logic [7:0]  code;
        logic [7:0]  lo_byte;
        logic [15:0] wr_word;
        logic        wr_pend;
        logic [15:0] limit_word;
        logic [15:0] current_word;
        logic [15:0] voltage_word;
        logic [33:0] wd_cnt;
        logic [20:0] low_cnt;
        logic        wd_exp;
        logic        low_exp;
        logic        sda_out;
        logic        sda_oe;
        dac_out_t    dac;
    } regs_t;

    regs_t   s;
    regs_t   next_s;
    bus_ev_t ev;
    logic    [15:0] rd_word;

    bus_pin_sync u_sync (
        .clk    (clk),
        .rst    (rst),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .ev     (ev)
    );

    // Clamp above the top, zero below the first step
    function automatic logic [15:0] effective(input logic [15:0] w, input logic [15:0] hi, input logic [15:0] lo);
        if (w < lo) begin
            return 16'h0000;
        end
        return (w > hi) ? hi : w;
    endfunction

    function automatic logic [15:0] read_word(input regs_t r);
        case (r.code)
            REG_CHARGE_CURRENT: return r.current_word;
            REG_CHARGE_VOLTAGE: return r.voltage_word;
            REG_INPUT_LIMIT:    return r.limit_word;
            REG_MAKER_ID:       return MAKER_ID;
            REG_PART_ID:        return PART_ID;
            default:            return 16'h0000;
        endcase
    endfunction

    assign rd_word = read_word(s);

    always_comb begin
        logic tx;
        logic acking;
        logic charge_write;
        next_s       = s;
        charge_write = 1'b0;
        tx           = (s.st == ST_SEND_LO) || (s.st == ST_SEND_HI);
        acking       = ((s.st == ST_ADDR) && (s.shreg[7:1] == SLAVE_ADDR)) || (s.st == ST_CODE)
                       || (s.st == ST_DATA_LO) || (s.st == ST_DATA_HI);

        if (ev.start) begin
            // A repeated start drops an unfinished write
            next_s.st      = ST_ADDR;
            next_s.bitcnt  = 4'h0;
            next_s.in_ack  = 1'b0;
            next_s.sda_oe  = 1'b0;
            next_s.wr_pend = 1'b0;
        end else if (ev.stop) begin
            if (s.wr_pend) begin
                case (s.code)
                    REG_INPUT_LIMIT:    next_s.limit_word = s.wr_word;
                    REG_CHARGE_CURRENT: begin
                        next_s.current_word = s.wr_word;
                        charge_write        = 1'b1;
                    end
                    REG_CHARGE_VOLTAGE: begin
                        next_s.voltage_word = s.wr_word;
                        charge_write        = 1'b1;
                    end
                    default: ;
                endcase
            end
            next_s.st      = ST_IDLE;
            next_s.in_ack  = 1'b0;
            next_s.sda_oe  = 1'b0;
            next_s.wr_pend = 1'b0;
        end else if (s.st != ST_IDLE) begin
            if (ev.scl_rise) begin
                if (s.in_ack) begin
                    next_s.nack = ev.sda;
                end else if (s.bitcnt < BITS_PER_BYTE) begin
                    next_s.bitcnt = s.bitcnt + 4'h1;
                    if (!tx) begin
                        next_s.shreg = {s.shreg[6:0], ev.sda};
                    end
                end
            end else if (ev.scl_fall) begin
                if (s.in_ack) begin
                    next_s.in_ack = 1'b0;
                    next_s.bitcnt = 4'h0;
                    next_s.sda_oe = 1'b0;
                    case (s.st)
                        ST_ADDR: begin
                            if (s.shreg[7:1] != SLAVE_ADDR) begin
                                next_s.st = ST_IDLE;
                            end else if (s.shreg[0]) begin
                                next_s.st     = ST_SEND_LO;
                                next_s.shreg  = rd_word[7:0];
                                next_s.sda_oe = ~rd_word[7];
                            end else begin
                                next_s.st = ST_CODE;
                            end
                        end
                        ST_CODE: begin
                            next_s.code = s.shreg;
                            next_s.st   = ST_DATA_LO;
                        end
                        ST_DATA_LO: begin
                            next_s.lo_byte = s.shreg;
                            next_s.st      = ST_DATA_HI;
                        end
                        ST_DATA_HI: begin
                            next_s.wr_word = {s.shreg, s.lo_byte};
                            next_s.wr_pend = 1'b1;
                            next_s.st      = ST_IGNORE;
                        end
                        ST_SEND_LO: begin
                            if (s.nack) begin
                                next_s.st = ST_IGNORE;
                            end else begin
                                next_s.st     = ST_SEND_HI;
                                next_s.shreg  = rd_word[15:8];
                                next_s.sda_oe = ~rd_word[15];
                            end
                        end
                        default: next_s.st = ST_IGNORE;
                    endcase
                end else if (s.bitcnt == BITS_PER_BYTE) begin
                    next_s.in_ack = 1'b1;
                    next_s.sda_oe = !tx && acking;
                end else if (tx && (s.bitcnt != 4'h0)) begin
                    next_s.shreg  = {s.shreg[6:0], 1'b0};
                    next_s.sda_oe = ~s.shreg[6];
                end
            end
        end

        // Clock-low watchdog; counter saturates so the flag holds while the line stays low
        if (ev.scl) begin
            next_s.low_cnt = '0;
        end else if (s.low_cnt != LOW_CYCLES) begin
            next_s.low_cnt = s.low_cnt + 21'h1;
        end
        if (charge_write) begin
            next_s.wd_cnt = '0;
        end else if (s.wd_cnt != WD_CYCLES) begin
            next_s.wd_cnt = s.wd_cnt + 34'h1;
        end
        if (charge_write) begin
            next_s.wd_exp  = 1'b0;
            next_s.low_exp = 1'b0;
        end
        // Set only on the step onto the limit; a saturated count must not block the clear of a later write
        if (s.wd_cnt == WD_CYCLES - 34'h1) begin
            next_s.wd_exp = 1'b1;
        end
        if (s.low_cnt == LOW_CYCLES) begin
            next_s.low_exp = 1'b1;
        end

        next_s.dac.limit   = LIMIT_W'(effective(s.limit_word, LIMIT_MAX_WORD, LIMIT_MIN_WORD) >> LIMIT_LSB);
        next_s.dac.current = CURRENT_W'(effective(s.current_word, CURRENT_MAX_WORD, CURRENT_MIN_WORD) >> CURRENT_LSB);
        next_s.dac.voltage = VOLTAGE_W'(effective(s.voltage_word, VOLTAGE_MAX_WORD, VOLTAGE_MIN_WORD) >> VOLTAGE_LSB);
        next_s.dac.enabled = (s.dac.current != '0) && (s.dac.voltage != '0) && !s.wd_exp && !s.low_exp;
        next_s.sda_out     = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s              <= '0;
            s.st           <= ST_IDLE;
            s.limit_word   <= LIMIT_RESET;
            s.current_word <= CHARGE_RESET;
            s.voltage_word <= CHARGE_RESET;
            s.dac.limit    <= LIMIT_RESET_CODE;
        end else begin
            s <= next_s;
        end
    end

    assign sda_out = s.sda_out;
    assign sda_oe  = s.sda_oe;
    assign dac     = s.dac;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_limit_clamp: assert property (dac.limit <= LIMIT_MAX_CODE)
        else $error("Limit code above maximum");
    a_limit_default: assert property ($past(rst) |-> dac.limit == LIMIT_RESET_CODE)
        else $error("Limit code not at reset step after reset");
    a_limit_low_zero: assert property ((s.limit_word < LIMIT_MIN_WORD) && $stable(s.limit_word) |=> dac.limit == '0)
        else $error("Small limit request did not give zero");
    a_commit_at_stop: assert property (!$stable(s.limit_word) |-> $past(ev.stop) && $past(s.wr_pend))
        else $error("Limit changed outside a completed write");
    a_ack_write: assert property (s.in_ack && (s.st inside {ST_CODE, ST_DATA_LO, ST_DATA_HI}) |-> s.sda_oe)
        else $error("Write byte not acknowledged");
    a_no_auto_advance: assert property (s.st == ST_IGNORE && s.in_ack |-> !s.sda_oe)
        else $error("Extra byte acknowledged");
    a_low_first: assert property ($past(s.st) == ST_ADDR && s.st == ST_SEND_LO |-> s.shreg == rd_word[7:0])
        else $error("Read did not start with the low byte");
    a_clock_low_stop: assert property (s.low_cnt == LOW_CYCLES |-> ##2 !dac.enabled)
        else $error("Charging kept on with clock held low");
    a_write_timeout: assert property ($rose(s.wd_exp) |-> ##1 !dac.enabled [*3])
        else $error("Charging kept on after write timeout");
    a_reset_off: assert property ($past(rst) |-> !dac.enabled ##1 !dac.enabled)
        else $error("Charging on straight after reset");
endmodule // smbus_charger_input_limit_regs
`default_nettype wire

// ==== rtl/charger_pkg.sv ====
// Package: register codes, field layouts, reset values, timing counts and carrier types
// for the charger SMBus register block. Assumes a 50 MHz system clock.
package charger_pkg;

    // Register codes
    localparam logic [7:0]  REG_CHARGE_CURRENT = 8'h14;
    localparam logic [7:0]  REG_CHARGE_VOLTAGE = 8'h15;
    localparam logic [7:0]  REG_INPUT_LIMIT    = 8'h3F;
    localparam logic [7:0]  REG_MAKER_ID       = 8'hFE;
    localparam logic [7:0]  REG_PART_ID        = 8'hFF;

    // Reset values and clamp points, in register LSBs
    localparam logic [15:0] LIMIT_RESET        = 16'h0080;
    localparam logic [15:0] CHARGE_RESET       = 16'h0000;
    localparam logic [15:0] LIMIT_MAX_WORD     = 16'h157E;
    localparam logic [15:0] LIMIT_MIN_WORD     = 16'h0080;
    localparam logic [15:0] CURRENT_MAX_WORD   = 16'h1F80;
    localparam logic [15:0] CURRENT_MIN_WORD   = 16'h0080;
    localparam logic [15:0] VOLTAGE_MAX_WORD   = 16'h4B00;
    localparam logic [15:0] VOLTAGE_MIN_WORD   = 16'h0400;

    // Field positions
    localparam int          LIMIT_LSB          = 7;
    localparam int          LIMIT_W            = 6;
    localparam int          CURRENT_LSB        = 7;
    localparam int          CURRENT_W          = 6;
    localparam int          VOLTAGE_LSB        = 4;
    localparam int          VOLTAGE_W          = 11;
    localparam logic [5:0]  LIMIT_MAX_CODE     = 6'(LIMIT_MAX_WORD >> LIMIT_LSB);
    localparam logic [5:0]  LIMIT_RESET_CODE   = 6'(LIMIT_RESET >> LIMIT_LSB);

    // Bus framing
    localparam logic [6:0]  SLAVE_ADDR_DEFAULT = 7'h09;
    localparam logic [3:0]  BITS_PER_BYTE      = 4'h8;

    // Timing
    localparam longint unsigned CLK_HZ          = 50_000_000;
    localparam longint unsigned WRITE_TIMEOUT_S = 175;
    localparam longint unsigned SCL_LOW_MS      = 25;
    localparam longint unsigned WRITE_TIMEOUT_CYC = WRITE_TIMEOUT_S * CLK_HZ;
    localparam longint unsigned SCL_LOW_CYC     = (SCL_LOW_MS * CLK_HZ) / 1000;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_CODE    = 3'b010,
        ST_DATA_LO = 3'b011,
        ST_DATA_HI = 3'b100,
        ST_SEND_LO = 3'b101,
        ST_SEND_HI = 3'b110,
        ST_IGNORE  = 3'b111
    } bus_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } bus_ev_t;

    typedef struct packed {
        logic [LIMIT_W-1:0]   limit;
        logic [CURRENT_W-1:0] current;
        logic [VOLTAGE_W-1:0] voltage;
        logic                 enabled;
    } dac_out_t;

endpackage

// ==== rtl/bus_pin_sync.sv ====
// Synchroniser and edge finder for the two bus pins.
// Assumes scl_in and sda_in are asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module bus_pin_sync (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output charger_pkg::bus_ev_t   ev
);
    import charger_pkg::*;

    typedef struct packed {
        logic [2:0] scl_p;
        logic [2:0] sda_p;
    } sync_t;

    sync_t s;
    sync_t next_s;

    always_comb begin
        next_s       = s;
        next_s.scl_p = {s.scl_p[1:0], scl_in};
        next_s.sda_p = {s.sda_p[1:0], sda_in};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    // Only stages 1 and 2 are looked at; stage 0 feeds stage 1 alone
    assign ev.scl      = s.scl_p[1];
    assign ev.sda      = s.sda_p[1];
    assign ev.scl_rise = s.scl_p[1] & ~s.scl_p[2];
    assign ev.scl_fall = ~s.scl_p[1] & s.scl_p[2];
    assign ev.start    = s.scl_p[1] & s.scl_p[2] & ~s.sda_p[1] & s.sda_p[2];
    assign ev.stop     = s.scl_p[1] & s.scl_p[2] & s.sda_p[1] & ~s.sda_p[2];
endmodule // bus_pin_sync
`default_nettype wire

// ==== verification/smbus_host_model.sv ====
// SMBus host model: drives SCL and the SDA pull-down, runs word writes and word reads.
// Assumes the bench resolves SDA as an open-drain wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    logic       dir_wr;
    logic       dir_rd;
    logic       ack_off;
    logic       ack_on;
    logic [7:0] released;

    // Clock stands high between frames; a bit is 8 clk, 160 ns
    initial begin
        scl      = 1'b1;
        sda_low  = 1'b0;
        dir_wr   = 1'b0;
        dir_rd   = 1'b1;
        ack_off  = 1'b0;
        ack_on   = 1'b1;
        released = 8'hFF;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic frame_start();
        wait_clk(4);
        sda_low = 1'b1;
        wait_clk(4);
        scl = 1'b0;
    endtask

    task automatic frame_stop();
        wait_clk(1);
        sda_low = 1'b1;
        wait_clk(3);
        scl = 1'b1;
        wait_clk(4);
        sda_low = 1'b0;
        wait_clk(4);
    endtask

    // SDA moves one clk after the SCL fall, so the device never sees it change under a high clock
    task automatic bit_xfer(input logic b, output logic seen);
        wait_clk(1);
        sda_low = ~b;
        wait_clk(3);
        scl = 1'b1;
        wait_clk(4);
        seen = sda;
        scl = 1'b0;
    endtask

    // Byte MSB first, then the ninth bit; host_ack pulls SDA low there
    task automatic byte_xfer(input logic [7:0] tx, input logic host_ack,
                             output logic [7:0] rx, output logic dev_ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(tx[i], s);
            rx[i] = s;
        end
        bit_xfer(~host_ack, s);
        dev_ack = ~s;
    endtask

    // Stop is left to the caller so the bench can look before the commit
    task automatic write_head(input logic [6:0] addr, input logic [7:0] code,
                              input logic [15:0] data, output logic [3:0] acks);
        logic [7:0] rx;
        frame_start();
        byte_xfer({addr, dir_wr}, ack_off, rx, acks[3]);
        byte_xfer(code, ack_off, rx, acks[2]);
        byte_xfer(data[7:0], ack_off, rx, acks[1]);
        byte_xfer(data[15:8], ack_off, rx, acks[0]);
    endtask

    task automatic read_word(input logic [6:0] addr, input logic [7:0] code,
                             output logic [15:0] data, output logic [2:0] acks);
        logic [7:0] rx;
        logic       na;
        frame_start();
        byte_xfer({addr, dir_wr}, ack_off, rx, acks[2]);
        byte_xfer(code, ack_off, rx, acks[1]);
        frame_stop();
        frame_start();
        byte_xfer({addr, dir_rd}, ack_off, rx, acks[0]);
        byte_xfer(released, ack_on, data[7:0], na);
        byte_xfer(released, ack_off, data[15:8], na);
        frame_stop();
    endtask

    task automatic hold_low(input int n);
        scl = 1'b0;
        wait_clk(n);
        scl = 1'b1;
        wait_clk(4);
    endtask
endmodule // smbus_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Testbench: word writes and reads over SMBus pins, DAC codes and both safety timers.
// Assumes short timer parameters: write timeout 2000 clk, clock-low limit 200 clk.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import charger_pkg::*;
    logic                  clk;
    logic                  rst;
    logic                  scl;
    logic                  sda_low;
    logic                  sda;
    logic                  sda_out;
    logic                  sda_oe;
    dac_out_t              dac;
    int                    n_fail;
    int                    cmp_count;
    logic [15:0]           rd;
    logic [3:0]            acks;
    logic [7:0]            rx;
    logic                  ack1;
    localparam logic [6:0][15:0] LIM_WORD = {16'h0080, 16'h007F, 16'h0F80, 16'h1000, 16'h157E, 16'h157F, 16'hFFFF};
    localparam logic [6:0][15:0] LIM_MA   = {16'd256, 16'd0, 16'd7936, 16'd8192, 16'd10752, 16'd10752, 16'd10752};

    assign sda = ~(sda_oe | sda_low);
    always #10 clk = ~clk;

    smbus_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    smbus_charger_input_limit_regs #(.WD_CYCLES(34'd2000), .LOW_CYCLES(21'd200)) uut (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .dac(dac));

    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        host.write_head(SLAVE_ADDR_DEFAULT, code, data, acks);
        check("write_acks", 24'hF, 24'(acks));
        host.frame_stop();
        idle(4);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        summarize();
    end

    initial begin
        clk       = 1'b0;
        rst       = 1'b1;
        n_fail    = 0;
        cmp_count = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check("limit_reset", 24'(LIMIT_RESET_CODE), 24'(dac.limit));
        check("charge_reset", 24'h0, 24'({dac.current, dac.voltage, dac.enabled}));
        host.read_word(SLAVE_ADDR_DEFAULT, REG_INPUT_LIMIT, rd, acks[2:0]);
        check("limit_read", 24'(LIMIT_RESET), 24'(rd));
        check("read_acks", 24'h7, 24'(acks[2:0]));
        check("sda_out_low", 24'h0, 24'(sda_out));
        // Bytes alone must not move the DAC; only the Stop commits
        host.write_head(SLAVE_ADDR_DEFAULT, REG_INPUT_LIMIT, 16'h41A0, acks);
        check("write_acks", 24'hF, 24'(acks));
        idle(8);
        check("limit_pre_stop", 24'(LIMIT_RESET_CODE), 24'(dac.limit));
        host.frame_stop();
        idle(4);
        check("limit_post_stop", 24'(LIMIT_MAX_CODE), 24'(dac.limit));
        host.read_word(SLAVE_ADDR_DEFAULT, REG_INPUT_LIMIT, rd, acks[2:0]);
        check("limit_readback", 24'h41A0, 24'(rd));
        for (int i = 6; i >= 0; i--) begin
            wr(REG_INPUT_LIMIT, LIM_WORD[i]);
            check("limit_ma", 24'(LIM_MA[i]), 24'({dac.limit, 8'h00}));
        end
        wr(REG_CHARGE_CURRENT, 16'h0100);
        check("current_code", 24'h2, 24'(dac.current));
        check("enabled_one", 24'h0, 24'(dac.enabled));
        wr(REG_CHARGE_VOLTAGE, 16'h1000);
        check("voltage_code", 24'h100, 24'(dac.voltage));
        check("enabled_both", 24'h1, 24'(dac.enabled));
        // A third data byte must be refused and must not spill into 0x15
        host.write_head(SLAVE_ADDR_DEFAULT, REG_CHARGE_CURRENT, 16'h0200, acks);
        host.byte_xfer(8'h55, host.ack_off, rx, ack1);
        check("extra_byte_ack", 24'h0, 24'(ack1));
        host.frame_stop();
        idle(4);
        check("one_register", 24'h2100, 24'({dac.current, dac.voltage}));
        host.frame_start();
        host.byte_xfer({7'h0A, host.dir_wr}, host.ack_off, rx, ack1);
        check("foreign_addr_ack", 24'h0, 24'(ack1));
        host.frame_stop();
        repeat (2) host.hold_low(190);
        check("low_restart", 24'h1, 24'(dac.enabled));
        host.hold_low(210);
        check("low_timeout", 24'h0, 24'(dac.enabled));
        idle(20);
        check("stays_off", 24'h0, 24'(dac.enabled));
        wr(REG_CHARGE_VOLTAGE, 16'h1000);
        check("low_reenable", 24'h1, 24'(dac.enabled));
        idle(1500);
        wr(REG_CHARGE_CURRENT, 16'h0100);
        idle(1500);
        check("write_restart", 24'h1, 24'(dac.enabled));
        idle(600);
        check("write_timeout", 24'h0, 24'(dac.enabled));
        wr(REG_CHARGE_CURRENT, 16'h0100);
        check("write_reenable", 24'h1, 24'(dac.enabled));
        summarize();
    end
endmodule // tb_top
`default_nettype wire
